// ### logic/uart_ier_status.sv
// interrupt enable, identification and line status registers of the uart
// Summary of operation
// - interrupt enable bit 5 switches low power mode on when 1
// - interrupt enable bit 4 allows sleep mode when 1
// - interrupt enable bit 3 gates the modem status interrupt
// - bit 2 gates line status interrupt, raised when a character lands
// - bit 1 gates transmitter empty interrupt, following holding empty
// - bit 0 gates receiver ready: trigger level in fifo mode, else data ready
// - all enables and power modes are zero after reset
// - fifo mode with bit 0 set: data interrupt at trigger, cleared below
// - identification shows trigger condition, clears with the interrupt
// - data ready set when a character enters, clear when fifo empty
// - line status bits 4 to 1 report receive error kinds
// - line status bit 5 is set while transmit fifo is empty
// - bit 6 set only when transmit fifo and shifter are empty
// - bit 7 set in fifo mode when any held character carries a data error
// - enabled sources are combined onto the single interrupt pin
// - fifo mode only while fifo enable is 1, else single byte
// - two-bit trigger field of fifo control selects receive level
`timescale 1ns/1ns
`default_nettype none
`include "uart_ier_defs.svh"
module uart_ier_status (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // host bus pins
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] d_in,
  output logic      [7:0] d_out,
  output logic            d_oe,
  // uart core status, same clock
  input  wire logic       divisor_access,
  input  wire logic [6:0] rx_count,
  input  wire logic       rx_push,
  input  wire logic [3:0] rx_err_kind,
  input  wire logic       rx_fifo_err,
  input  wire logic       tx_fifo_empty,
  input  wire logic       tx_shift_empty,
  input  wire logic       modem_change,
  // controls to the uart core
  output logic            fifo_en,
  output logic            fifo64_en,
  output logic            dma_mode,
  output logic            rx_fifo_reset,
  output logic            tx_fifo_reset,
  output logic            sleep_en,
  output logic            low_power_en,
  // interrupt pin
  output logic            int_out
);
  logic [`PIN_W-1:0] pin_raw;
  logic [`PIN_W-1:0] s1_q;
  logic [`PIN_W-1:0] s2_q;
  logic [`PIN_W-1:0] s3_q;
  logic [`PIN_W-1:0] pin_q;
  logic [5:0]        ier_q;
  logic [7:0]        fcr_q;
  logic              ls_pend_q;
  logic              rx_reset_q;
  logic              tx_reset_q;
  logic [7:0]        d_out_q;
  logic              d_oe_q;
  uart_ier_pkg::bus_state_t bus_q;
  uart_ier_pkg::bus_state_t bus_d;
  rx_trigger_if      trig ();
  // idle level of the sampled pins, one bit per pin position
  localparam logic [`PIN_W-1:0] pin_idle = `PIN_IDLE;

  // three-stage pin sampler, a change counts once stages two and three agree
  assign pin_raw = {cs_n, rd_n, wr_n, addr, d_in};
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_W; gi = gi + 1) begin : g_pin
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[gi]  <= pin_idle[gi];
          s2_q[gi]  <= pin_idle[gi];
          s3_q[gi]  <= pin_idle[gi];
          pin_q[gi] <= pin_idle[gi];
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            pin_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // filtered pin fields
  wire       sel_cs   = ~pin_q[13];
  wire       act_rd   = ~pin_q[12];
  wire       act_wr   = ~pin_q[11];
  wire [2:0] pin_addr = pin_q[10:8];
  wire [7:0] pin_data = pin_q[7:0];

  // address decode, interrupt enable only while divisor access is off
  wire hit_ier = (pin_addr == `ADDR_IER) && !divisor_access;
  wire hit_ifc = (pin_addr == `ADDR_ISR_FCR);
  wire hit_lsr = (pin_addr == `ADDR_LSR);

  // bus phase: a write is taken when the strobe is released
  wire rd_start = sel_cs && act_rd && !act_wr;
  wire wr_start = sel_cs && act_wr && !act_rd;
  wire wr_done  = (bus_q == uart_ier_pkg::bus_write) && !act_wr;
  wire rd_done  = (bus_q == uart_ier_pkg::bus_read) && !act_rd;
  wire wr_ier   = wr_done && hit_ier;
  wire wr_fcr   = wr_done && hit_ifc;
  wire rd_lsr   = rd_done && hit_lsr;

  // bus phase sequencing
  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      uart_ier_pkg::bus_idle: begin
        if (rd_start) begin
          bus_d = uart_ier_pkg::bus_read;
        end else if (wr_start) begin
          bus_d = uart_ier_pkg::bus_write;
        end
      end
      uart_ier_pkg::bus_read: begin
        if (!act_rd) begin
          bus_d = uart_ier_pkg::bus_idle;
        end
      end
      uart_ier_pkg::bus_write: begin
        if (!act_wr) begin
          bus_d = uart_ier_pkg::bus_idle;
        end
      end
      default: begin
        bus_d = uart_ier_pkg::bus_idle;
      end
    endcase
  end

  // bus phase register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= uart_ier_pkg::bus_idle;
    end else begin
      bus_q <= bus_d;
    end
  end

  // interrupt enable register, top two bits not stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ier_q <= `IER_RESET;
    end else if (wr_ier) begin
      ier_q <= pin_data[5:0];
    end
  end

  // fifo control register; reset bits act as one-cycle pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fcr_q      <= `FCR_RESET;
      rx_reset_q <= 1'b0;
      tx_reset_q <= 1'b0;
    end else begin
      rx_reset_q <= wr_fcr && pin_data[`FCR_RX_RESET];
      tx_reset_q <= wr_fcr && pin_data[`FCR_TX_RESET];
      if (wr_fcr) begin
        fcr_q <= pin_data;
      end
    end
  end

  // fifo mode and trigger selection
  wire fifo_mode = fcr_q[`FCR_FIFO_EN];
  assign trig.sel    = fcr_q[`FCR_TRIG_MSB:`FCR_TRIG_LSB];
  assign trig.fifo64 = fcr_q[`FCR_FIFO64];
  assign trig.count  = rx_count;

  rx_trigger_unit u_trig (
    .trig (trig)
  );

  // line status bits
  wire data_ready = (rx_count != 7'h00);
  wire tx_hold_mt = tx_fifo_empty;
  wire tx_all_mt  = tx_fifo_empty && tx_shift_empty;
  wire fifo_err   = fifo_mode && rx_fifo_err;
  wire [7:0] lsr_val = {fifo_err, tx_all_mt, tx_hold_mt,
                        rx_err_kind, data_ready};

  // line status event: set on character arrival, cleared by status read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ls_pend_q <= 1'b0;
    end else if (rx_push) begin
      ls_pend_q <= 1'b1;
    end else if (rd_lsr) begin
      ls_pend_q <= 1'b0;
    end
  end

  // source conditions, level at trigger in fifo mode
  wire rx_cond  = fifo_mode ? trig.reached : data_ready;
  wire src_ls   = ier_q[`IER_LINE_STAT] && ls_pend_q;
  wire src_rx   = ier_q[`IER_RX_READY] && rx_cond;
  wire src_tx   = ier_q[`IER_TX_EMPTY] && tx_hold_mt;
  wire src_md   = ier_q[`IER_MODEM] && modem_change;
  wire any_src  = src_ls || src_rx || src_tx || src_md;

  // identification by priority, trigger condition shown
  wire [2:0] id_code = src_ls ? `ISR_LINE_STAT :
                       src_rx ? `ISR_RX_READY :
                       src_tx ? `ISR_TX_EMPTY :
                       src_md ? `ISR_MODEM : `ISR_NONE;
  wire [7:0] isr_val = {fifo_mode, fifo_mode, trig.fifo64 && fifo_mode,
                        1'b0, id_code, !any_src};

  // read data mux
  wire [7:0] rd_val = hit_ier ? {2'b00, ier_q} :
                      hit_ifc ? isr_val :
                      hit_lsr ? lsr_val : 8'h00;

  // read data and drive enable registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_out_q <= 8'h00;
      d_oe_q  <= 1'b0;
    end else begin
      d_oe_q <= (bus_q == uart_ier_pkg::bus_read) && act_rd && sel_cs;
      if (rd_start && bus_q == uart_ier_pkg::bus_idle) begin
        d_out_q <= rd_val;
      end
    end
  end

  // outputs
  assign d_out         = d_out_q;
  assign d_oe          = d_oe_q;
  assign fifo_en       = fifo_mode;
  assign fifo64_en     = fcr_q[`FCR_FIFO64];
  assign dma_mode      = fcr_q[`FCR_DMA_MODE];
  assign rx_fifo_reset = rx_reset_q;
  assign tx_fifo_reset = tx_reset_q;
  assign low_power_en  = ier_q[`IER_LOW_POWER];
  assign sleep_en      = ier_q[`IER_SLEEP];
  assign int_out       = any_src;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_low_power_bit: assert property (
    wr_ier |=> low_power_en == $past(pin_data[`IER_LOW_POWER]))
    else $error("low power enable does not follow write");
  a_sleep_bit_hold: assert property (
    !wr_ier |=> sleep_en == $past(sleep_en))
    else $error("sleep enable changed without write");
  a_modem_gate: assert property (
    (modem_change && !ier_q[`IER_MODEM] && !src_ls && !src_rx
     && !src_tx) |-> !int_out)
    else $error("modem interrupt not suppressed");
  a_line_stat_set: assert property (
    (rx_push && ier_q[`IER_LINE_STAT] && !wr_ier) |=> int_out)
    else $error("line status interrupt missing");
  a_tx_empty_int: assert property (
    (ier_q[`IER_TX_EMPTY] && tx_fifo_empty) |-> int_out)
    else $error("transmitter empty interrupt missing");
  a_rx_withdraw: assert property (
    (fifo_mode && !trig.reached && !ls_pend_q && !src_tx && !src_md)
    |-> !int_out)
    else $error("receive interrupt held below trigger");
  a_rx_trigger: assert property (
    (fifo_mode && ier_q[`IER_RX_READY] && trig.reached) |-> int_out)
    else $error("receive interrupt missing at trigger");
  a_reset_clear: assert property (
    $rose(rst_n) |-> ier_q == `IER_RESET)
    else $error("enables not cleared by reset");
  a_isr_pending: assert property (
    (src_rx && !src_ls) |-> isr_val[3:0] == {`ISR_RX_READY, 1'b0})
    else $error("identification misses trigger condition");
  a_data_ready: assert property (
    (rx_count == 7'h00) |-> !lsr_val[0])
    else $error("data ready set with empty fifo");
  a_tx_all_empty: assert property (
    lsr_val[6] |-> (tx_fifo_empty && tx_shift_empty && lsr_val[5]))
    else $error("transmitter empty flag wrong");
  a_top_bits_zero: assert property (
    (bus_q == uart_ier_pkg::bus_idle && rd_start && hit_ier)
    |=> d_out[7:6] == 2'b00)
    else $error("enable bits 7 and 6 not read as zero");
  a_polled_quiet: assert property (
    (ier_q[3:0] == 4'h0) |-> !int_out)
    else $error("interrupt with all sources disabled");

  c_rx_trigger: cover property (fifo_mode && src_rx ##[1:20] !src_rx);
  c_line_stat:  cover property (src_ls ##[1:40] rd_lsr);
  c_tx_int:     cover property (wr_ier ##1 src_tx);
  c_polled:     cover property (fifo_mode && ier_q == 6'h00 && data_ready);
endmodule : uart_ier_status
`default_nettype wire

// ### logic/uart_ier_defs.svh
// register addresses, field positions, reset values and trigger levels
`ifndef UART_IER_DEFS_SVH
`define UART_IER_DEFS_SVH
// register addresses on the three address pins
`define ADDR_IER        3'h1
`define ADDR_ISR_FCR    3'h2
`define ADDR_LSR        3'h5
// interrupt enable fields
`define IER_RX_READY    0
`define IER_TX_EMPTY    1
`define IER_LINE_STAT   2
`define IER_MODEM       3
`define IER_SLEEP       4
`define IER_LOW_POWER   5
`define IER_WR_MASK     8'h3f
`define IER_RESET       6'h00
// fifo control fields
`define FCR_FIFO_EN     0
`define FCR_RX_RESET    1
`define FCR_TX_RESET    2
`define FCR_DMA_MODE    3
`define FCR_FIFO64      5
`define FCR_TRIG_LSB    6
`define FCR_TRIG_MSB    7
`define FCR_RESET       8'h00
// identification codes, bit 0 is the low-active pending flag
`define ISR_NONE        3'h0
`define ISR_LINE_STAT   3'h3
`define ISR_RX_READY    3'h2
`define ISR_TX_EMPTY    3'h1
`define ISR_MODEM       3'h0
// receive trigger levels, 16-byte and 64-byte modes
`define TRIG16_0        7'h01
`define TRIG16_1        7'h04
`define TRIG16_2        7'h08
`define TRIG16_3        7'h0e
`define TRIG64_0        7'h01
`define TRIG64_1        7'h10
`define TRIG64_2        7'h20
`define TRIG64_3        7'h38
// pin sampler width and reset level (idle high)
`define PIN_W           14
`define PIN_IDLE        14'h3fff
`define COUNT_W         7
`endif

// ### logic/uart_ier_pkg.sv
// types shared by the interrupt enable and status logic
package uart_ier_pkg;
  // host bus access phases
  typedef enum logic [1:0] {
    bus_idle,
    bus_read,
    bus_write
  } bus_state_t;
endpackage : uart_ier_pkg

// ### logic/rx_trigger_if.sv
// carrier between the register logic and the trigger comparator
`timescale 1ns/1ns
`default_nettype none
interface rx_trigger_if;
  logic [1:0] sel;      // trigger field of fifo control
  logic       fifo64;   // 64-byte fifo mode
  logic [6:0] count;    // receive fifo occupancy
  logic       reached;  // occupancy at or above trigger
  modport ctl  (output sel, output fifo64, output count, input reached);
  modport unit (input sel, input fifo64, input count, output reached);
endinterface : rx_trigger_if
`default_nettype wire

// ### logic/rx_trigger_unit.sv
// receive trigger level selection and occupancy compare
`timescale 1ns/1ns
`default_nettype none
`include "uart_ier_defs.svh"
module rx_trigger_unit (
  // link to register logic
  rx_trigger_if.unit trig
);
  wire [`COUNT_W-1:0] lvl16;
  wire [`COUNT_W-1:0] lvl64;
  wire [`COUNT_W-1:0] level;

  // level decode from the two-bit field
  assign lvl16 = (trig.sel == 2'h0) ? `TRIG16_0 :
                 (trig.sel == 2'h1) ? `TRIG16_1 :
                 (trig.sel == 2'h2) ? `TRIG16_2 : `TRIG16_3;
  assign lvl64 = (trig.sel == 2'h0) ? `TRIG64_0 :
                 (trig.sel == 2'h1) ? `TRIG64_1 :
                 (trig.sel == 2'h2) ? `TRIG64_2 : `TRIG64_3;
  assign level = trig.fifo64 ? lvl64 : lvl16;

  // set at the level, drops as soon as occupancy falls below
  assign trig.reached = (trig.count >= level);
endmodule : rx_trigger_unit
`default_nettype wire

// ### verif/host_bus_model.sv
// host processor model driving the register bus pins of the uart
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  // clock
  input  wire logic       clk,
  // bus pins toward the device
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [2:0] addr,
  output logic      [7:0] d_in,
  // read data from the device
  input  wire logic [7:0] d_out,
  input  wire logic       d_oe
);
  int n;
  // idle bus at time zero
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
    d_in = 8'h00;
  end
  // write cycle; data stays until well after the strobe rises
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    addr = a;
    d_in = d;
    wr_n = 1'b0;
    repeat (5) @(negedge clk);
    wr_n = 1'b1;
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    d_in = ~d; // released bus no longer shows the old byte
    repeat (5) @(negedge clk);
  endtask : wr
  // read cycle; strobe held until the device drives the bus
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    addr = a;
    rd_n = 1'b0;
    n = 0;
    while (d_oe !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    d = (n < 20) ? d_out : 8'hxx;
    repeat (4) @(negedge clk);
    rd_n = 1'b1;
    n = 0;
    while (d_oe !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cs_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

// ### verif/uart_interrupt_enable_status_test.sv
// self-checking bench for the interrupt enable and line status logic
`timescale 1ns/1ns
`default_nettype none
`include "uart_ier_defs.svh"
module uart_interrupt_enable_status_test;
  logic       clk, rst_n, cs_n, rd_n, wr_n, d_oe, rx_push, rx_fifo_err;
  logic       tx_fifo_empty, tx_shift_empty, modem_change, int_out;
  logic       sleep_en, low_power_en, fifo_en, fifo64_en, dma_mode;
  logic       rx_fifo_reset, tx_fifo_reset;
  logic [7:0] rx_rst_cnt, tx_rst_cnt;
  logic [2:0] addr;
  logic [7:0] d_in, d_out, rv, v;
  logic [6:0] rx_count;
  logic [3:0] rx_err_kind;
  logic [6:0] lv [4];
  int         err_count, comparisons, seed;
  // device under test
  uart_ier_status i_uart_ier_status (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
    .divisor_access(1'b0), .rx_count(rx_count), .rx_push(rx_push),
    .rx_err_kind(rx_err_kind), .rx_fifo_err(rx_fifo_err),
    .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty),
    .modem_change(modem_change), .fifo_en(fifo_en), .fifo64_en(fifo64_en),
    .dma_mode(dma_mode), .rx_fifo_reset(rx_fifo_reset),
    .tx_fifo_reset(tx_fifo_reset), .sleep_en(sleep_en),
    .low_power_en(low_power_en), .int_out(int_out));
  // host on the register bus
  host_bus_model i_host_bus_model (
    .clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .d_in(d_in), .d_out(d_out), .d_oe(d_oe));
  // count the fifo reset pulses seen by the core
  initial begin
    rx_rst_cnt = 8'h00;
    tx_rst_cnt = 8'h00;
  end
  always @(posedge clk) begin
    if (rx_fifo_reset === 1'b1) rx_rst_cnt <= rx_rst_cnt + 8'h01;
    if (tx_fifo_reset === 1'b1) tx_rst_cnt <= tx_rst_cnt + 8'h01;
  end
  // 250 mhz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // compare one value and count it
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // print counts and verdict, then stop
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // expected interrupt pin from enables and core inputs
  function automatic logic exp_int(input logic [7:0] ie, input logic f,
                                   input logic [6:0] lvl, input logic ls);
    logic rx;
    rx = f ? (rx_count >= lvl) : (rx_count != 7'h00);
    return (ls & ie[2]) | (rx & ie[0]) | (tx_fifo_empty & ie[1]) |
           (modem_change & ie[3]);
  endfunction : exp_int
  // hang guard
  initial begin
    #100000;
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end
  // main sequence
  initial begin
    seed = 43;
    rst_n = 1'b0;
    rx_count = 7'h00;
    rx_push = 1'b0;
    rx_err_kind = 4'h0;
    rx_fifo_err = 1'b0;
    tx_fifo_empty = 1'b0;
    tx_shift_empty = 1'b0;
    modem_change = 1'b0;
    lv = '{`TRIG16_0, `TRIG16_1, `TRIG16_2, `TRIG16_3};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    i_host_bus_model.rd(`ADDR_IER, v);
    check(v, 8'h00, "enable reset");
    check({6'h00, sleep_en, low_power_en}, 8'h00, "power reset");
    $display("test reset done");
    // single enables first, then random; sources on and random
    for (int i = 0; i < 10; i++) begin
      rv = (i < 4) ? (8'hc0 | (8'h01 << i)) : 8'($random(seed));
      i_host_bus_model.wr(`ADDR_IER, rv);
      i_host_bus_model.rd(`ADDR_IER, v);
      check(v, rv & 8'h3f, "enable readback");
      check({7'h00, sleep_en}, {7'h00, rv[4]}, "sleep");
      check({7'h00, low_power_en}, {7'h00, rv[5]}, "low power");
      rx_count = 7'($random(seed)) & 7'h03;
      tx_fifo_empty = 1'($random(seed));
      modem_change = 1'($random(seed));
      #1 check({7'h00, int_out}, {7'h00, exp_int(rv, 0, 0, 0)}, "irq");
      @(negedge clk);
      rx_count = 7'h01;
      tx_fifo_empty = 1'b1;
      modem_change = 1'b1;
      #1 check({7'h00, int_out}, {7'h00, exp_int(rv, 0, 0, 0)}, "irq");
    end
    $display("test enables done");
    // trigger levels in fifo mode, then fifo off
    tx_fifo_empty = 1'b0;
    modem_change = 1'b0;
    i_host_bus_model.wr(`ADDR_IER, 8'h01);
    for (int s = 0; s < 4; s++) begin
      i_host_bus_model.wr(`ADDR_ISR_FCR, {2'(s), 6'h01});
      rx_count = lv[s] - 7'h01;
      #1 check({7'h00, int_out}, 8'h00, "below level");
      i_host_bus_model.rd(`ADDR_ISR_FCR, v);
      check(v, 8'hc1, "ident below");
      rx_count = lv[s];
      #1 check({7'h00, int_out}, 8'h01, "at level");
      i_host_bus_model.rd(`ADDR_ISR_FCR, v);
      check(v, 8'hc4, "ident at level");
      rx_count = lv[s] - 7'h01;
      #1 check({7'h00, int_out}, 8'h00, "drop below");
    end
    i_host_bus_model.wr(`ADDR_ISR_FCR, 8'hc0);
    rx_count = 7'h01;
    #1 check({7'h00, int_out}, 8'h01, "single byte");
    check({5'h00, dma_mode, fifo64_en, fifo_en}, 8'h00, "fifo off");
    i_host_bus_model.wr(`ADDR_ISR_FCR, 8'h2e);
    check({5'h00, dma_mode, fifo64_en, fifo_en}, 8'h06, "fifo modes");
    check(rx_rst_cnt, 8'h01, "rx fifo reset pulse");
    check(tx_rst_cnt, 8'h01, "tx fifo reset pulse");
    $display("test trigger done");
    // line status interrupt on a landed character, cleared by reading
    i_host_bus_model.wr(`ADDR_ISR_FCR, 8'h01);
    i_host_bus_model.wr(`ADDR_IER, 8'h04);
    rx_push = 1'b1;
    @(negedge clk);
    rx_push = 1'b0;
    #1 check({7'h00, int_out}, 8'h01, "line irq set");
    i_host_bus_model.rd(`ADDR_LSR, v);
    #1 check({7'h00, int_out}, 8'h00, "line irq clear");
    // polled mode: fifos on, all four enables cleared
    i_host_bus_model.wr(`ADDR_IER, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rx_count = (i == 0) ? 7'h00 : 7'($random(seed)) & 7'h3f;
      rx_err_kind = 4'($random(seed));
      rx_fifo_err = 1'($random(seed));
      tx_fifo_empty = 1'($random(seed));
      tx_shift_empty = 1'($random(seed));
      rx_push = 1'b1;
      @(negedge clk);
      rx_push = 1'b0;
      i_host_bus_model.rd(`ADDR_LSR, v);
      check(v, {rx_fifo_err, tx_fifo_empty & tx_shift_empty, tx_fifo_empty,
                rx_err_kind, rx_count != 7'h00}, "status");
      check({7'h00, int_out}, 8'h00, "polled quiet");
    end
    $display("test line status done");
    complete_run();
  end
endmodule : uart_interrupt_enable_status_test
`default_nettype wire
